// File: src/dlcc_pkg.sv
// Shared constants and types for directed link change control
package dlcc_pkg;

    // ------------------------------
    // Encodings
    // ------------------------------
    localparam logic [1:0] DLCC_REQ_NONE  = 2'h0;
    localparam logic [1:0] DLCC_REQ_WIDTH = 2'h1;
    localparam logic [1:0] DLCC_REQ_SPEED = 2'h2;
    localparam logic [1:0] DLCC_REQ_BOTH  = 2'h3;
    localparam logic       DLCC_SPD_2G5   = 1'h0;
    localparam logic       DLCC_SPD_5G0   = 1'h1;
    localparam logic [1:0] DLCC_WID_X1    = 2'h0;
    localparam logic [1:0] DLCC_WID_X2    = 2'h1;
    localparam logic [1:0] DLCC_WID_X4    = 2'h2;
    localparam logic [1:0] DLCC_WID_X8    = 2'h3;
    localparam logic [1:0] DLCC_AUTO_SPD_ON = 2'h3;
    localparam logic [5:0] DLCC_TS_DETECT = 6'h00;
    localparam logic [5:0] DLCC_TS_L0     = 6'h16;
    localparam logic [5:0] DLCC_TS_RECOV  = 6'h1c;
    localparam logic [5:0] DLCC_TS_HOTRST = 6'h21;

    // ------------------------------
    // Timing, clock 10 MHz
    // ------------------------------
    localparam int DLCC_CLK_NS      = 100;
    localparam int DLCC_CHANGE_NS   = 2000;
    localparam int DLCC_RETRAIN_NS  = 3000;
    localparam int DLCC_HOTRST_NS   = 2000;
    localparam int DLCC_CHANGE_CYC  = DLCC_CHANGE_NS / DLCC_CLK_NS;
    localparam int DLCC_RETRAIN_CYC = DLCC_RETRAIN_NS / DLCC_CLK_NS;
    localparam int DLCC_HOTRST_CYC  = DLCC_HOTRST_NS / DLCC_CLK_NS;

    // ------------------------------
    // Controller registers (byte addresses) and fields
    // ------------------------------
    localparam logic [11:0] DLCC_OFS_CTRL  = 12'h000;
    localparam logic [11:0] DLCC_OFS_STAT  = 12'h004;
    localparam logic [11:0] DLCC_OFS_IRQ   = 12'h008;
    localparam logic [11:0] DLCC_OFS_MASK  = 12'h00c;
    localparam int DLCC_CTRL_REQ   = 0;   // [1:0]
    localparam int DLCC_CTRL_SPD   = 2;
    localparam int DLCC_CTRL_WID   = 3;   // [4:3]
    localparam int DLCC_CTRL_EPDE  = 5;
    localparam int DLCC_CTRL_RPDE  = 6;
    localparam int DLCC_CTRL_AUTON = 7;
    localparam int DLCC_CTRL_GO    = 8;
    localparam int DLCC_CTRL_HRST  = 9;
    localparam int DLCC_CTRL_RP    = 10;
    localparam int DLCC_CTRL_ASPD  = 11;  // [12:11]
    localparam logic [12:0] DLCC_CTRL_RST = 13'h0000;
    localparam logic [12:0] DLCC_CTRL_WMASK = 13'h1cff;
    localparam int DLCC_IRQ_DONE   = 0;
    localparam int DLCC_IRQ_HOTRST = 1;
    localparam int DLCC_IRQ_RXRST  = 2;
    localparam int DLCC_IRQ_REFUSE = 3;
    localparam int DLCC_IRQ_W      = 4;
    localparam logic [3:0] DLCC_IRQ_RST = 4'h0;

    // ------------------------------
    // State types
    // ------------------------------
    typedef enum logic [4:0] {
        DLCC_P_L0      = 5'b0_0001,
        DLCC_P_RECOV   = 5'b0_0010,
        DLCC_P_DONE    = 5'b0_0100,
        DLCC_P_HOTRST  = 5'b0_1000,
        DLCC_P_RETRAIN = 5'b1_0000
    } dlcc_port_st_t;

    typedef enum logic [3:0] {
        DLCC_U_IDLE    = 4'b0001,
        DLCC_U_CHANGE  = 4'b0010,
        DLCC_U_RELEASE = 4'b0100,
        DLCC_U_HOTRST  = 4'b1000
    } dlcc_user_st_t;

endpackage

// File: src/dlcc_if.sv
// Interface joining the port end and the user application end
`timescale 1ns/10ps
interface dlcc_if;
    logic       link_up;
    logic [1:0] link_change_request;
    logic       target_speed_select;
    logic [1:0] target_width_select;
    logic       change_reason_autonomous;
    logic       change_complete;
    logic       endpoint_deemphasis_pref;
    logic       rootport_deemphasis_src;
    logic       inband_reset_seen;
    logic       send_inband_reset;
    logic [5:0] training_state;
    logic       partner_fast_capable;

    // The documented port
    modport port_mp (
        output link_up, change_complete, inband_reset_seen, training_state,
        output partner_fast_capable,
        input  link_change_request, target_speed_select, target_width_select,
        input  change_reason_autonomous, endpoint_deemphasis_pref,
        input  rootport_deemphasis_src, send_inband_reset
    );

    // The user application logic
    modport user_mp (
        input  link_up, change_complete, inband_reset_seen, training_state,
        input  partner_fast_capable,
        output link_change_request, target_speed_select, target_width_select,
        output change_reason_autonomous, endpoint_deemphasis_pref,
        output rootport_deemphasis_src, send_inband_reset
    );
endinterface

// File: src/dlcc_port.sv
// Port end: physical layer directed change and hot reset behaviour
`timescale 1ns/10ps
module dlcc_port (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       role_rootport,
    input  wire logic       phy_link_ok,
    input  wire logic       phy_partner_gen2,
    input  wire logic       phy_partner_deemph_3p5,
    input  wire logic       phy_rx_hot_reset,
    input  wire logic       lc2_deemph_3p5,
    output logic [1:0]      cur_width,
    output logic            cur_speed,
    output logic            tx_deemph_3p5,
    output logic            last_change_auton,
    dlcc_if.port_mp         lnk
);
    import dlcc_pkg::*;

    // ------------------------------
    // Pin synchronisers
    // ------------------------------
    logic [3:0] meta_reg;
    logic [3:0] sync_reg;
    wire        link_ok_s  = sync_reg[0];
    wire        gen2_s     = sync_reg[1];
    wire        pdeemph_s  = sync_reg[2];
    wire        rx_hrst_s  = sync_reg[3];
    logic       rx_hrst_d_reg;
    wire        rx_hrst_edge = rx_hrst_s & ~rx_hrst_d_reg;

    // Two stages before anything reads the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg      <= 4'h0;
            sync_reg      <= 4'h0;
            rx_hrst_d_reg <= 1'b0;
        end else begin
            meta_reg      <= {phy_rx_hot_reset, phy_partner_deemph_3p5,
                              phy_partner_gen2, phy_link_ok};
            sync_reg      <= meta_reg;
            rx_hrst_d_reg <= rx_hrst_s;
        end
    end

    // ------------------------------
    // Training state machine
    // ------------------------------
    dlcc_port_st_t state_reg, state_next;
    logic [7:0]    cnt_reg;
    logic [1:0]    width_reg;
    logic          speed_reg;
    logic          auton_reg;
    wire           cnt_zero  = (cnt_reg == 8'h00);
    wire           req_any   = (lnk.link_change_request != DLCC_REQ_NONE);
    wire           tx_hrst   = role_rootport & lnk.send_inband_reset;
    wire           rx_hrst   = ~role_rootport & rx_hrst_edge;
    wire           in_l0     = (state_reg == DLCC_P_L0) & link_ok_s;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            DLCC_P_L0: begin
                if (tx_hrst | rx_hrst)
                    state_next = DLCC_P_HOTRST;
                else if (req_any & link_ok_s)
                    state_next = DLCC_P_RECOV;
            end
            DLCC_P_RECOV: begin
                if (cnt_zero)
                    state_next = DLCC_P_DONE;
            end
            // Level request: done stands until none
            DLCC_P_DONE: begin
                if (!req_any)
                    state_next = DLCC_P_L0;
            end
            // Root port waits for send to drop
            DLCC_P_HOTRST: begin
                if (role_rootport ? !lnk.send_inband_reset : cnt_zero)
                    state_next = DLCC_P_RETRAIN;
            end
            DLCC_P_RETRAIN: begin
                if (cnt_zero)
                    state_next = DLCC_P_L0;
            end
        endcase
    end

    // State, counter and applied link settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= DLCC_P_L0;
            cnt_reg   <= 8'h00;
            width_reg <= DLCC_WID_X1;
            speed_reg <= DLCC_SPD_2G5;
            auton_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_next != state_reg) begin
                unique case (state_next)
                    DLCC_P_RECOV:   cnt_reg <= 8'(DLCC_CHANGE_CYC - 1);
                    DLCC_P_HOTRST:  cnt_reg <= 8'(DLCC_HOTRST_CYC - 1);
                    DLCC_P_RETRAIN: cnt_reg <= 8'(DLCC_RETRAIN_CYC - 1);
                    default:        cnt_reg <= 8'h00;
                endcase
            end else if (!cnt_zero) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
            // apply the selected change at the end of recovery
            if (state_reg == DLCC_P_RECOV && cnt_zero) begin
                if (lnk.link_change_request[0])
                    width_reg <= lnk.target_width_select;
                // speed only to 5.0 when partner can
                if (lnk.link_change_request[1])
                    speed_reg <= lnk.target_speed_select & gen2_s;
                auton_reg <= lnk.change_reason_autonomous;
            end
            if (state_next == DLCC_P_RETRAIN)
                speed_reg <= DLCC_SPD_2G5;
        end
    end

    // ------------------------------
    // Outputs toward the user
    // ------------------------------
    assign lnk.link_up              = in_l0 | (state_reg == DLCC_P_DONE)
                                      | (state_reg == DLCC_P_RECOV);
    assign lnk.change_complete      = (state_reg == DLCC_P_DONE);
    assign lnk.inband_reset_seen    = ~role_rootport & (state_reg == DLCC_P_HOTRST);
    assign lnk.partner_fast_capable = gen2_s;
    assign lnk.training_state = (state_reg == DLCC_P_HOTRST)  ? DLCC_TS_HOTRST :
                                (state_reg == DLCC_P_RECOV)   ? DLCC_TS_RECOV  :
                                (state_reg == DLCC_P_RETRAIN || !link_ok_s)
                                                              ? DLCC_TS_DETECT : DLCC_TS_L0;

    // endpoint preference; root port source select
    wire deemph_sel = role_rootport ? (lnk.rootport_deemphasis_src ? lc2_deemph_3p5 : pdeemph_s)
                                    : lnk.endpoint_deemphasis_pref;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_deemph_3p5 <= 1'b0;
        end else begin
            tx_deemph_3p5 <= (speed_reg == DLCC_SPD_5G0) & deemph_sel;
        end
    end

    assign cur_width         = width_reg;
    assign cur_speed         = speed_reg;
    assign last_change_auton = auton_reg;

endmodule

// File: src/dlcc_user.sv
// User end: APB-controlled sequencer for directed changes and hot reset
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module dlcc_user (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    dlcc_if.user_mp          lnk
);
    import dlcc_pkg::*;

    // ------------------------------
    // Helpers
    // ------------------------------
    // Speed part of a request code is present
    function automatic logic req_has_speed(input logic [1:0] code);
        return code[1];
    endfunction

    // ------------------------------
    // APB decode
    // ------------------------------
    wire setup     = psel & ~penable;
    wire access    = psel & penable;
    wire hit_ctrl  = (paddr == DLCC_OFS_CTRL);
    wire hit_stat  = (paddr == DLCC_OFS_STAT);
    wire hit_irq   = (paddr == DLCC_OFS_IRQ);
    wire hit_mask  = (paddr == DLCC_OFS_MASK);
    wire hit_any   = hit_ctrl | hit_stat | hit_irq | hit_mask;
    wire wr_ctrl   = access & pwrite & hit_ctrl;
    wire wr_irq    = access & pwrite & hit_irq;
    wire wr_mask   = access & pwrite & hit_mask;

    // Zero wait states
    assign pready  = access;
    assign pslverr = access & ~hit_any;

    // ------------------------------
    // Registers
    // ------------------------------
    logic [12:0]          ctrl_reg;
    logic [DLCC_IRQ_W-1:0] irq_reg;
    logic [DLCC_IRQ_W-1:0] irq_next;
    logic [DLCC_IRQ_W-1:0] mask_reg;
    dlcc_user_st_t        state_reg, state_next;
    logic [1:0]           req_reg;
    logic                 spd_reg;
    logic [1:0]           wid_reg;
    logic                 epde_reg;
    logic                 rpde_reg;
    logic                 auton_reg;
    logic                 hrst_reg;
    logic                 rxrst_d_reg;

    // A write with GO is judged on the word it writes
    wire [12:0] ctrl_src = wr_ctrl ? (pwdata[12:0] & DLCC_CTRL_WMASK) : ctrl_reg;
    wire [1:0] c_req   = ctrl_src[DLCC_CTRL_REQ +: 2];
    wire [1:0] c_wid   = ctrl_src[DLCC_CTRL_WID +: 2];
    wire [1:0] c_aspd  = ctrl_src[DLCC_CTRL_ASPD +: 2];
    wire       c_spd   = ctrl_src[DLCC_CTRL_SPD];
    wire       c_rp    = ctrl_src[DLCC_CTRL_RP];
    wire       go      = wr_ctrl & pwdata[DLCC_CTRL_GO];
    wire       hgo     = wr_ctrl & pwdata[DLCC_CTRL_HRST];
    wire       idle    = (state_reg == DLCC_U_IDLE);

    // ------------------------------------------------------------
    // Start checks
    // ------------------------------------------------------------
    // link must be up
    wire ok_link  = lnk.link_up;
    // root port speed codes need auto speed enabled
    wire ok_auto  = ~c_rp | ~req_has_speed(c_req) | (c_aspd == DLCC_AUTO_SPD_ON);
    // fast target only with a capable partner
    wire ok_fast  = ~(c_spd == DLCC_SPD_5G0) | lnk.partner_fast_capable;
    wire ok_code  = (c_req != DLCC_REQ_NONE);
    wire start_ok = idle & go & ok_link & ok_auto & ok_fast & ok_code;
    // hot reset only in the root port role
    wire hrst_ok  = idle & hgo & c_rp & ~go;
    wire refused  = (go & ~start_ok) | (hgo & ~c_rp);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            DLCC_U_IDLE: begin
                if (start_ok)
                    state_next = DLCC_U_CHANGE;
                else if (hrst_ok)
                    state_next = DLCC_U_HOTRST;
            end
            // hold request and targets until done
            DLCC_U_CHANGE: begin
                if (lnk.change_complete)
                    state_next = DLCC_U_RELEASE;
            end
            // Request to none; wait for done low
            DLCC_U_RELEASE: begin
                if (!lnk.change_complete)
                    state_next = DLCC_U_IDLE;
            end
            // send stays high until hot reset state is seen
            DLCC_U_HOTRST: begin
                if (lnk.training_state == DLCC_TS_HOTRST)
                    state_next = DLCC_U_IDLE;
            end
        endcase
    end

    // Sticky events; a new event wins over a clearing write
    always_comb begin
        irq_next = irq_reg;
        if (wr_irq)
            irq_next = irq_reg & ~pwdata[DLCC_IRQ_W-1:0];
        if (state_reg == DLCC_U_CHANGE && lnk.change_complete)
            irq_next[DLCC_IRQ_DONE] = 1'b1;
        if (state_reg == DLCC_U_HOTRST && state_next == DLCC_U_IDLE)
            irq_next[DLCC_IRQ_HOTRST] = 1'b1;
        if (lnk.inband_reset_seen & ~rxrst_d_reg)
            irq_next[DLCC_IRQ_RXRST] = 1'b1;
        if (refused)
            irq_next[DLCC_IRQ_REFUSE] = 1'b1;
    end

    // Registers; GO and HRST never store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg    <= DLCC_CTRL_RST;
            mask_reg    <= DLCC_IRQ_RST;
            irq_reg     <= DLCC_IRQ_RST;
            rxrst_d_reg <= 1'b0;
            state_reg   <= DLCC_U_IDLE;
        end else begin
            if (wr_ctrl)
                ctrl_reg <= ctrl_src;
            if (wr_mask)
                mask_reg <= pwdata[DLCC_IRQ_W-1:0];
            irq_reg     <= irq_next;
            rxrst_d_reg <= lnk.inband_reset_seen;
            state_reg   <= state_next;
        end
    end

    // Port inputs from flops; change request fields latched at start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_reg   <= DLCC_REQ_NONE;
            spd_reg   <= DLCC_SPD_2G5;
            wid_reg   <= DLCC_WID_X1;
            epde_reg  <= 1'b0;
            rpde_reg  <= 1'b0;
            auton_reg <= 1'b0;
            hrst_reg  <= 1'b0;
        end else begin
            // level request held through the change
            if (state_next == DLCC_U_CHANGE && idle) begin
                req_reg   <= c_req;
                spd_reg   <= c_spd;
                wid_reg   <= c_wid;
                // preference latched at the start of every change, width-only requests too
                epde_reg  <= ctrl_src[DLCC_CTRL_EPDE];
                auton_reg <= ctrl_src[DLCC_CTRL_AUTON];
            end else if (state_next == DLCC_U_RELEASE) begin
                req_reg   <= DLCC_REQ_NONE;
            end
            // root port source is a static choice
            rpde_reg <= ctrl_reg[DLCC_CTRL_RPDE];
            // assert send; drop once hot reset is seen
            hrst_reg <= (state_next == DLCC_U_HOTRST);
        end
    end

    assign lnk.link_change_request      = req_reg;
    assign lnk.target_speed_select      = spd_reg;
    assign lnk.target_width_select      = wid_reg;
    assign lnk.endpoint_deemphasis_pref = epde_reg;
    assign lnk.rootport_deemphasis_src  = rpde_reg;
    assign lnk.change_reason_autonomous = auton_reg;
    assign lnk.send_inband_reset        = hrst_reg;

    // ------------------------------------------------------------
    // Read data and interrupt
    // ------------------------------------------------------------
    wire [31:0] stat_word = {21'h00_0000, lnk.inband_reset_seen, lnk.training_state,
                             (state_reg == DLCC_U_HOTRST), ~idle,
                             lnk.partner_fast_capable, lnk.link_up};
    wire [31:0] rd_mux = hit_ctrl ? {19'h0_0000, ctrl_reg} :
                         hit_stat ? stat_word :
                         hit_irq  ? {28'h000_0000, irq_reg} :
                         hit_mask ? {28'h000_0000, mask_reg} : 32'h0000_0000;

    // Captured in setup, shown in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= rd_mux;
        end
    end

    assign irq = |(irq_reg & mask_reg);

endmodule

// File: bench/dlcc_properties.sv
// Checker for the link between the port end and the user end
`timescale 1ns/10ps
module dlcc_properties
    import dlcc_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       link_up,
    input wire logic [1:0] link_change_request,
    input wire logic       target_speed_select,
    input wire logic       change_complete,
    input wire logic       inband_reset_seen,
    input wire logic       send_inband_reset,
    input wire logic [5:0] training_state,
    input wire logic       partner_fast_capable
);
    // ------------------------------
    // Link checks, one clock domain
    // ------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Request leaves the no-change code
    sequence s_start;
        link_change_request != DLCC_REQ_NONE && $past(link_change_request) == DLCC_REQ_NONE;
    endsequence
    // Recovery entered
    sequence s_recov;
        $rose(training_state == DLCC_TS_RECOV);
    endsequence
    chk_start_link_up: assert property (s_start |-> link_up)
        else $error("change started with link down");
    chk_speed_capable: assert property ((s_start ##0 (target_speed_select
        && link_change_request[1])) |-> partner_fast_capable)
        else $error("fast speed asked of slow partner");
    chk_req_held: assert property (link_change_request != DLCC_REQ_NONE && !change_complete
        |=> $stable(link_change_request))
        else $error("request moved before completion");
    chk_done_time: assert property (s_recov |-> ##[18:22] $rose(change_complete))
        else $error("completion not on time");
    chk_done_needs_req: assert property ($rose(change_complete)
        |-> link_change_request != DLCC_REQ_NONE)
        else $error("completion without request");
    chk_done_holds: assert property (change_complete && link_change_request != DLCC_REQ_NONE
        |=> change_complete)
        else $error("completion dropped early");
    chk_hotrst_entry: assert property ($rose(send_inband_reset)
        |-> ##[1:3] training_state == DLCC_TS_HOTRST)
        else $error("hot reset state not entered");
    chk_send_held: assert property (send_inband_reset && training_state != DLCC_TS_HOTRST
        |=> send_inband_reset)
        else $error("send released too soon");
    chk_seen_state: assert property (inband_reset_seen
        |-> training_state == DLCC_TS_HOTRST)
        else $error("reset seen outside hot reset");
    chk_seen_len: assert property ($rose(inband_reset_seen) |=> inband_reset_seen [*8])
        else $error("reset seen too short");
endmodule

// File: bench/tb_directed_link_change_control.sv
// Self-checking bench: both ends joined, control through APB
`timescale 1ns/10ps
module tb_directed_link_change_control;
    import dlcc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic        role_rootport, phy_link_ok, phy_partner_gen2, phy_partner_deemph_3p5;
    logic        phy_rx_hot_reset, lc2_deemph_3p5, cur_speed, tx_deemph_3p5, last_change_auton;
    logic [1:0]  cur_width;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          n_errors = 0, compares = 0, cycles = 0;
    dlcc_if lnk ();
    dlcc_port dlcc_port_inst (.pclk, .presetn, .role_rootport, .phy_link_ok, .phy_partner_gen2,
        .phy_partner_deemph_3p5, .phy_rx_hot_reset, .lc2_deemph_3p5, .cur_width, .cur_speed,
        .tx_deemph_3p5, .last_change_auton, .lnk(lnk.port_mp));
    dlcc_user dlcc_user_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq, .lnk(lnk.user_mp));
    dlcc_properties dlcc_properties_inst (.pclk, .presetn, .link_up(lnk.link_up),
        .link_change_request(lnk.link_change_request), .change_complete(lnk.change_complete),
        .target_speed_select(lnk.target_speed_select), .training_state(lnk.training_state),
        .inband_reset_seen(lnk.inband_reset_seen), .send_inband_reset(lnk.send_inband_reset),
        .partner_fast_capable(lnk.partner_fast_capable));
    // ------------------------------
    // Clock, watchdog and helpers
    // ------------------------------
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Request held until pready high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask
    task automatic wait_reg(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
        int n = 0;
        do begin
            apb(1'b0, a, 32'h0000_0000);
            n++;
        end while ((rd & m) !== v && n < 200);
        check("poll", v, rd & m);
    endtask
    // Upper byte: aspd, role, hrst, go, auton, rp src, ep pref
    function automatic logic [31:0] cfg(input logic [1:0] rq, input logic sp,
                                        input logic [1:0] wd, input logic [7:0] hi);
        return {19'h0, hi, wd, sp, rq};
    endfunction
    // One change, wait for its bit, clear all
    task automatic change(input logic [31:0] c, input logic [31:0] bitv);
        apb(1'b1, DLCC_OFS_CTRL, c | 32'h0000_0100);
        wait_reg(DLCC_OFS_IRQ, bitv, bitv);
        wait_reg(DLCC_OFS_STAT, 32'h0000_0004, 32'h0000_0000);
        apb(1'b1, DLCC_OFS_IRQ, 32'h0000_000f);
    endtask
    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic t_regs();
        apb(1'b0, DLCC_OFS_MASK, 32'h0000_0000);
        check("mask", 32'h0000_0000, rd);
        apb(1'b1, DLCC_OFS_CTRL, 32'h0000_1cff);
        apb(1'b0, DLCC_OFS_CTRL, 32'h0000_0000);
        check("ctrl", 32'h0000_1cff, rd);
        apb(1'b1, DLCC_OFS_CTRL, 32'h0000_0000);
        apb(1'b0, 12'h010, 32'h0000_0000);
        check("slverr", 32'h0000_0001, {31'h0, err});
    endtask
    task automatic t_width();
        for (int w = 3; w >= 0; w--) begin
            change(cfg(DLCC_REQ_WIDTH, 1'b0, 2'(w), 8'h04), 32'h0000_0001);
            check("width", 32'(w), {30'h0, cur_width});
        end
        check("auton", 32'h0000_0001, {31'h0, last_change_auton});
    endtask
    task automatic t_speed();
        change(cfg(DLCC_REQ_SPEED, DLCC_SPD_5G0, 2'h0, 8'h01), 32'h0000_0001);
        check("speed", 32'h0000_0003, {30'h0, cur_speed, tx_deemph_3p5});
        change(cfg(DLCC_REQ_BOTH, DLCC_SPD_5G0, DLCC_WID_X4, 8'h00), 32'h0000_0001);
        check("both", 32'h0000_0004, {29'h0, cur_width, tx_deemph_3p5});
        change(cfg(DLCC_REQ_SPEED, DLCC_SPD_2G5, 2'h0, 8'h01), 32'h0000_0001);
        check("slow", 32'h0000_0000, {30'h0, cur_speed, tx_deemph_3p5});
    endtask
    task automatic t_refuse();
        phy_partner_gen2 <= 1'b0;
        change(cfg(DLCC_REQ_SPEED, DLCC_SPD_5G0, 2'h0, 8'h00), 32'h0000_0008);
        role_rootport <= 1'b1;
        change(cfg(DLCC_REQ_BOTH, 1'b0, 2'h0, 8'h20), 32'h0000_0008);
        phy_link_ok <= 1'b0;
        change(cfg(DLCC_REQ_WIDTH, 1'b0, DLCC_WID_X8, 8'h00), 32'h0000_0008);
        check("kept", 32'h0000_0002, {30'h0, cur_width});
        {phy_link_ok, phy_partner_gen2} <= 2'h3;
        wait_reg(DLCC_OFS_STAT, 32'h0000_0003, 32'h0000_0003);
    endtask
    task automatic t_root();
        for (int s = 0; s < 2; s++) begin
            change(cfg(DLCC_REQ_SPEED, DLCC_SPD_5G0, 2'h0, 8'he0 | 8'(s * 2)), 32'h1);
            check("rp_deemph", 32'(1 - s), {31'h0, tx_deemph_3p5});
        end
        apb(1'b1, DLCC_OFS_CTRL, cfg(DLCC_REQ_NONE, 1'b0, 2'h0, 8'hf0));
        wait_reg(DLCC_OFS_IRQ, 32'h0000_0002, 32'h0000_0002);
        wait_reg(DLCC_OFS_STAT, 32'h0000_03f0, 32'h0000_0160);
        check("retrain", 32'h0000_0000, {31'h0, cur_speed});
        apb(1'b1, DLCC_OFS_IRQ, 32'h0000_000f);
    endtask
    task automatic t_rxrst();
        role_rootport <= 1'b0;
        phy_rx_hot_reset <= 1'b1;
        wait_reg(DLCC_OFS_IRQ, 32'h0000_0004, 32'h0000_0004);
        check("masked", 32'h0000_0000, {31'h0, irq});
        apb(1'b1, DLCC_OFS_MASK, 32'h0000_0004);
        phy_rx_hot_reset <= 1'b0;
        @(negedge pclk);
        check("irq", 32'h0000_0001, {31'h0, irq});
        apb(1'b1, DLCC_OFS_IRQ, 32'h0000_0004);
        @(negedge pclk);
        check("cleared", 32'h0000_0000, {31'h0, irq});
        wait_reg(DLCC_OFS_STAT, 32'h0000_03f0, 32'h0000_0160);
    endtask
    task automatic final_report();
        if (n_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        {role_rootport, phy_rx_hot_reset, lc2_deemph_3p5} = '0;
        {phy_link_ok, phy_partner_gen2, phy_partner_deemph_3p5} = '1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        wait_reg(DLCC_OFS_STAT, 32'h0000_0001, 32'h0000_0001);
        t_regs();
        t_width();
        t_speed();
        t_refuse();
        t_root();
        t_rxrst();
        final_report();
    end
endmodule
